// ===== common/cbsc_defines.svh
// Constants for the core boundary signal conditioning block
// Assumes inclusion by bare name from design files
`ifndef CBSC_DEFINES_SVH
`define CBSC_DEFINES_SVH
`define CBSC_SYNC_STAGES 3
`define CBSC_NUM_ASYNC 4
`define CBSC_IDX_COLD 0
`define CBSC_IDX_WARM 1
`define CBSC_IDX_NMI 2
`define CBSC_IDX_DINT 3
`define CBSC_NUM_STATIC 8
`define CBSC_NUM_STATIC_OUTPUT_CLASS 4
`define CBSC_STATIC_OUTPUT_CLASS_VALUE 4'h5
`define CBSC_SYNC_WIDTH 8
`endif

// ===== common/cbsc_pkg.sv
// Types for the core boundary signal conditioning block
// Assumes the defines header is on the include path
`default_nettype none
`include "cbsc_defines.svh"
package cbsc_pkg;
   typedef enum logic [1:0] {
      ED_IDLE = 2'b00,
      ED_HIGH = 2'b01
   } cbsc_edge_t;
endpackage
`default_nettype wire

// ===== hw/cbsc_boundary.sv
// Boundary conditioning at the edge of a processor core
// Assumes one core clock; static inputs held by the system outside cold reset
// Function
// RULE1: Ordinary synchronous inputs are captured on the rising core clock edge.
// RULE2: Ordinary synchronous outputs change only at the rising core clock edge.
// RULE3: Asynchronous inputs pass own synchronisation logic before any use.
// RULE4: System keeps static inputs unchanged while cold reset is deasserted.
// RULE5: Static outputs to the coprocessor are constant, never changing.
// RULE6: Signals are active high; names with low suffix assert when low.
// RULE7: NMI and debug interrupt are edge detected: one request per assertion.
// RULE8: Test-logic reset is the only active-low boundary signal; the code's rstn input is active low as well.
// RULE9: NMI is posted when sampled high after being sampled low.
// RULE10: Core clock is the reference edge for all boundary inputs and outputs.
// RULE11: Each asynchronous input passes at least two flip-flops before use.
`default_nettype none
`include "cbsc_defines.svh"
module cbsc_boundary
(
   input wire logic clk, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic coldResetIn, // Async cold reset request
   input wire logic warmResetIn, // Async soft reset request
   input wire logic nmiIn, // Async non-maskable interrupt
   input wire logic debugIrqIn, // Async debug interrupt
   input wire logic testLogicResetLow, // Test-logic reset, active low, async
   input wire logic [`CBSC_SYNC_WIDTH-1:0] syncIn, // Synchronous data input
   input wire logic [`CBSC_NUM_STATIC-1:0] staticIn, // Static configuration
   output logic [`CBSC_SYNC_WIDTH-1:0] syncOut, // Registered copy of syncIn
   output logic [`CBSC_NUM_STATIC-1:0] staticOut, // Static config, taken in cold reset
   output logic [`CBSC_NUM_STATIC_OUTPUT_CLASS-1:0] coprocStaticOut, // Constant coprocessor options
   output logic coldReset, // Synchronised cold reset level
   output logic warmReset, // Synchronised soft reset level
   output logic nmiReq, // One-cycle NMI request pulse
   output logic debugIrqReq, // One-cycle debug interrupt pulse
   output logic testLogicReset // Synchronised test reset, active high
);
   // ****************************************
   // Synchronisers
   // ****************************************
   logic [`CBSC_NUM_ASYNC-1:0] asyncRaw;
   logic [`CBSC_NUM_ASYNC-1:0] asyncSync;
   logic testResetSync;
   logic coldSync;

   // Inverted so the synchroniser's reset level reads as cold reset held
   assign asyncRaw[`CBSC_IDX_COLD] = ~coldResetIn;
   assign coldSync = ~asyncSync[`CBSC_IDX_COLD];
   assign asyncRaw[`CBSC_IDX_WARM] = warmResetIn;
   assign asyncRaw[`CBSC_IDX_NMI] = nmiIn;
   assign asyncRaw[`CBSC_IDX_DINT] = debugIrqIn;

   genvar gi;
   generate
      for (gi = 0; gi < `CBSC_NUM_ASYNC; gi++)
      begin : gSync
         cbsc_sync uSync
         (
            .clk(clk),
            .rstn(rstn),
            .asyncIn(asyncRaw[gi]), // RULE3
            .syncOut(asyncSync[gi]) // RULE11
         );
      end
   endgenerate

   // Fed as is, so the synchroniser resets to the asserted (low) level
   cbsc_sync uTestSync
   (
      .clk(clk),
      .rstn(rstn),
      .asyncIn(testLogicResetLow), // RULE8
      .syncOut(testResetSync) // RULE6
   );

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [`CBSC_SYNC_WIDTH-1:0] data;
      logic [`CBSC_NUM_STATIC-1:0] cfg;
      cbsc_pkg::cbsc_edge_t nmiEdge;
      cbsc_pkg::cbsc_edge_t dintEdge;
      logic nmiPulse;
      logic dintPulse;
      logic cold;
      logic warm;
      logic tst;
   } cbsc_state_t;

   cbsc_state_t st_reg;
   cbsc_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.data = syncIn; // RULE1
      // Static inputs only trusted while cold reset holds them
      if (coldSync)
      begin
         st_next.cfg = staticIn; // RULE4
      end
      st_next.cold = coldSync;
      st_next.warm = asyncSync[`CBSC_IDX_WARM];
      st_next.tst = ~testResetSync;
      st_next.nmiPulse = 1'b0;
      case (st_reg.nmiEdge)
         cbsc_pkg::ED_IDLE:
         begin
            if (asyncSync[`CBSC_IDX_NMI])
            begin
               st_next.nmiPulse = 1'b1; // RULE9
               st_next.nmiEdge = cbsc_pkg::ED_HIGH;
            end
         end
         cbsc_pkg::ED_HIGH:
         begin
            if (!asyncSync[`CBSC_IDX_NMI])
            begin
               st_next.nmiEdge = cbsc_pkg::ED_IDLE;
            end
         end
         default:
         begin
            st_next.nmiEdge = cbsc_pkg::ED_IDLE;
         end
      endcase
      st_next.dintPulse = 1'b0;
      case (st_reg.dintEdge)
         cbsc_pkg::ED_IDLE:
         begin
            if (asyncSync[`CBSC_IDX_DINT])
            begin
               st_next.dintPulse = 1'b1; // RULE7
               st_next.dintEdge = cbsc_pkg::ED_HIGH;
            end
         end
         cbsc_pkg::ED_HIGH:
         begin
            if (!asyncSync[`CBSC_IDX_DINT])
            begin
               st_next.dintEdge = cbsc_pkg::ED_IDLE;
            end
         end
         default:
         begin
            st_next.dintEdge = cbsc_pkg::ED_IDLE;
         end
      endcase
   end

   // Edge states reset to ED_HIGH, yet synchronisers reset low, so a level high at reset release still posts a request
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
         st_reg.nmiEdge <= cbsc_pkg::ED_HIGH;
         st_reg.dintEdge <= cbsc_pkg::ED_HIGH;
         st_reg.cold <= 1'b1;
         st_reg.tst <= 1'b1;
      end
      else
      begin
         st_reg <= st_next; // RULE10
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign syncOut = st_reg.data; // RULE2
   assign staticOut = st_reg.cfg;
   assign coprocStaticOut = `CBSC_STATIC_OUTPUT_CLASS_VALUE; // RULE5
   assign coldReset = st_reg.cold;
   assign warmReset = st_reg.warm;
   assign nmiReq = st_reg.nmiPulse;
   assign debugIrqReq = st_reg.dintPulse;
   assign testLogicReset = st_reg.tst;

   // ****************************************
   // Checks
   // ****************************************
   chk_nmi_one_pulse: assert property (@(posedge clk) disable iff (!rstn) // RULE7
      nmiReq |=> !nmiReq)
      else $error("NMI request longer than one cycle");
   chk_nmi_edge_cause: assert property (@(posedge clk) disable iff (!rstn) // RULE9
      $rose(asyncSync[`CBSC_IDX_NMI]) |=> nmiReq)
      else $error("NMI rising edge did not post a request");
   chk_nmi_no_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE9
      nmiReq |-> $past(asyncSync[`CBSC_IDX_NMI]) && !$past(asyncSync[`CBSC_IDX_NMI], 2))
      else $error("NMI request without low-to-high sample");
   chk_dint_edge: assert property (@(posedge clk) disable iff (!rstn) // RULE7
      $rose(asyncSync[`CBSC_IDX_DINT]) |=> debugIrqReq ##1 !debugIrqReq)
      else $error("Debug interrupt edge not a single pulse");
   chk_sync_capture: assert property (@(posedge clk) disable iff (!rstn) // RULE1
      ##1 syncOut == $past(syncIn))
      else $error("Synchronous input not captured");
   chk_cold_latency: assert property (@(posedge clk) disable iff (!rstn) // RULE11
      coldReset != $past(coldReset) |-> $past(coldResetIn, 4) == coldReset)
      else $error("Cold reset changed without synchroniser delay");
   chk_static_output_class_const: assert property (@(posedge clk) disable iff (!rstn) // RULE5
      $stable(coprocStaticOut))
      else $error("Static coprocessor output changed");
   chk_test_polarity: assert property (@(posedge clk) disable iff (!rstn) // RULE8
      (testLogicResetLow [*6]) |-> !testLogicReset)
      else $error("Test reset asserted while input high");
   chk_cfg_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE4
      !coldReset && !$past(coldReset) |-> $stable(staticOut))
      else $error("Static config changed outside cold reset");
   chk_cold_held_high: assert property (@(posedge clk) disable iff (!rstn) // RULE3
      (coldResetIn [*6]) |-> coldReset)
      else $error("Cold reset dropped while its pin is held high");
   chk_warm_latency: assert property (@(posedge clk) disable iff (!rstn) // RULE11
      warmReset != $past(warmReset) |-> $past(warmResetIn, 4) == warmReset)
      else $error("Warm reset changed without synchroniser delay");
   chk_dint_no_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE7
      debugIrqReq |-> $past(asyncSync[`CBSC_IDX_DINT]) && !$past(asyncSync[`CBSC_IDX_DINT], 2))
      else $error("Debug request without low-to-high sample");
   chk_test_assert: assert property (@(posedge clk) disable iff (!rstn) // RULE8
      (!testLogicResetLow [*6]) |-> testLogicReset)
      else $error("Test reset not asserted while input low");
endmodule
`default_nettype wire

// ===== hw/cbsc_sync.sv
// Three-stage synchroniser; a change counts when stages two and three agree
// Assumes one clock and an asynchronous active-low reset
`default_nettype none
`include "cbsc_defines.svh"
module cbsc_sync
(
   input wire logic clk, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic asyncIn, // Unsynchronised level
   output logic syncOut // Filtered synchronised level
);
   typedef struct packed {
      logic [`CBSC_SYNC_STAGES-1:0] stage;
      logic level;
   } cbsc_sync_state_t;

   cbsc_sync_state_t st_reg;
   cbsc_sync_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.stage = {st_reg.stage[1:0], asyncIn};
      if (st_reg.stage[1] == st_reg.stage[2])
      begin
         st_next.level = st_reg.stage[2];
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign syncOut = st_reg.level;
endmodule
`default_nettype wire

// ===== sim/cbsc_sys_model.sv
// System logic model that drives cold reset and static configuration
// Assumes the bench changes its requests at the falling clock edge
`default_nettype none
module cbsc_sys_model
(
   input wire logic clk, // Core clock
   input wire logic coldReq, // Bench asks for cold reset
   input wire logic [7:0] cfgReq, // Wanted configuration
   output logic coldResetIn, // Cold reset pin, active high
   output var logic [7:0] staticIn // Static configuration pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************
   // Pins
   // ************
   assign coldResetIn = coldReq;
   // Config may move only while cold reset is held; later requests are dropped
   always @(negedge clk)
      if (coldResetIn)
         staticIn <= cfgReq;
endmodule
`default_nettype wire

// ===== sim/tb_cbsc_boundary.sv
// Self-checking bench for the core boundary conditioning block
// Assumes the design files and the system model are compiled first
`default_nettype none
`include "cbsc_defines.svh"
module tb_cbsc_boundary;
   timeunit 1ns;
   timeprecision 100ps;
   // ************
   // Signals
   // ************
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic coldReq = 1'b1;
   logic [7:0] cfgReq = 8'h3c;
   logic [3:0] pins = 4'h0;
   logic [7:0] syncIn = 8'h00;
   logic coldResetIn;
   logic [7:0] staticIn, syncOut, staticOut;
   logic [3:0] coprocStaticOut, obs;
   logic coldReset, warmReset, nmiReq, debugIrqReq, testLogicReset;
   int failures = 0;
   int comparisons = 0;
   assign obs = {testLogicReset, debugIrqReq, nmiReq, warmReset};
   always #12.5 clk = ~clk;
   cbsc_sys_model u_cbsc_sys_model (.clk(clk), .coldReq(coldReq), .cfgReq(cfgReq),
      .coldResetIn(coldResetIn), .staticIn(staticIn));
   // Test reset pin is active low, so the bench inverts its request bit
   cbsc_boundary u_cbsc_boundary (.clk(clk), .rstn(rstn), .coldResetIn(coldResetIn),
      .warmResetIn(pins[0]), .nmiIn(pins[1]), .debugIrqIn(pins[2]),
      .testLogicResetLow(~pins[3]), .syncIn(syncIn), .staticIn(staticIn),
      .syncOut(syncOut), .staticOut(staticOut), .coprocStaticOut(coprocStaticOut),
      .coldReset(coldReset), .warmReset(warmReset), .nmiReq(nmiReq),
      .debugIrqReq(debugIrqReq), .testLogicReset(testLogicReset));
   // ************
   // Tasks
   // ************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic test_reset();
      chk("coproc", {4'h0, `CBSC_STATIC_OUTPUT_CLASS_VALUE}, {4'h0, coprocStaticOut});
      chk("coldReset", 8'h01, {7'h0, coldReset});
      chk("nmiReq", 8'h00, {7'h0, nmiReq});
      chk("testReset", 8'h01, {7'h0, testLogicReset});
      $display("test reset done");
   endtask
   task automatic test_static();
      chk("static", 8'h3c, staticOut);
      cfgReq = 8'hc3;
      repeat (3) @(negedge clk);
      chk("static", 8'hc3, staticOut);
      coldReq = 1'b0;
      repeat (6) @(negedge clk);
      chk("coldReset", 8'h00, {7'h0, coldReset});
      cfgReq = 8'h81;
      repeat (4) @(negedge clk);
      chk("static", 8'hc3, staticOut);
      $display("test static done");
   endtask
   task automatic test_sync();
      logic [7:0] v [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
      foreach (v[j])
      begin
         syncIn = v[j];
         @(negedge clk);
         chk("syncOut", v[j], syncOut);
      end
      $display("test sync done");
   endtask
   // Holds the pin high 12 cycles; a pulse shows once, a level from cycle 5 on
   task automatic test_async(input int i, input int fst, input int cnt, input string what);
      int n = 0;
      int first = 0;
      pins[i] = 1'b1;
      for (int k = 1; k <= 12; k++)
      begin
         @(negedge clk);
         if (obs[i] === 1'b1)
         begin
            n++;
            if (first == 0)
               first = k;
         end
      end
      pins[i] = 1'b0;
      repeat (8) @(negedge clk);
      chk({what, " latency"}, fst[7:0], first[7:0]);
      chk({what, " count"}, cnt[7:0], n[7:0]);
      $display("test %s done", what);
   endtask
   // ************
   // Sequence
   // ************
   initial
   begin
      repeat (2) @(negedge clk);
      test_reset();
      @(negedge clk);
      rstn = 1'b1;
      repeat (6) @(negedge clk);
      test_static();
      test_sync();
      test_async(0, 5, 8, "warm");
      test_async(1, 5, 1, "nmi");
      test_async(1, 5, 1, "nmi again");
      test_async(2, 5, 1, "debug");
      test_async(3, 5, 8, "test reset");
      chk("coproc", {4'h0, `CBSC_STATIC_OUTPUT_CLASS_VALUE}, {4'h0, coprocStaticOut});
      wrap_up();
   end
   // Tests need about 130 cycles; give them 400
   initial
   begin
      #(25 * 400);
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire
